// ---- common/amau_defs.vh ----
// Purpose: Constants for the operand address unit
// Assumes: 8-bit data bus, 16-bit address space
// Notes: Mode codes are the decoder's own encoding
`ifndef AMAU_DEFS_VH
`define AMAU_DEFS_VH

// Addressing modes
`define AMAU_M_INH      5'h00
`define AMAU_M_IMM      5'h01
`define AMAU_M_DIR_S    5'h02
`define AMAU_M_DIR_L    5'h03
`define AMAU_M_IDX_0    5'h04
`define AMAU_M_IDX_S    5'h05
`define AMAU_M_IDX_L    5'h06
`define AMAU_M_IND_S    5'h07
`define AMAU_M_IND_L    5'h08
`define AMAU_M_INX_S    5'h09
`define AMAU_M_INX_L    5'h0a
`define AMAU_M_REL_D    5'h0b
`define AMAU_M_REL_I    5'h0c
`define AMAU_M_BIT_D    5'h0d
`define AMAU_M_BIT_I    5'h0e
`define AMAU_M_BTR_D    5'h0f
`define AMAU_M_BTR_I    5'h10

// Families
`define AMAU_F_INH      3'h0
`define AMAU_F_IMM      3'h1
`define AMAU_F_DIR      3'h2
`define AMAU_F_IDX      3'h3
`define AMAU_F_IND      3'h4
`define AMAU_F_REL      3'h5
`define AMAU_F_BIT      3'h6

// Interrupt mask levels
`define AMAU_MASK_HI    2'h3
`define AMAU_MASK_LO    2'h0

`define AMAU_PAGE0_HI   8'h00
`define AMAU_ZERO8      8'h00
`define AMAU_ONE16      16'h0001

`endif

// ---- hdl/amau_add16.v ----
// Purpose: Unsigned 16-bit adder with a registered result
// Assumes: Operands stable when load is high
// Notes: Used for indexed sums and the relative target
`timescale 1ns/1ps
module amau_add16 (
   input wire i_clk,
   input wire i_arst_n,
   input wire i_load,
   input wire [15:0] i_a,
   input wire [15:0] i_b,
   output reg [15:0] o_sum
);
   wire [16:0] full_sum;
   // Carry dropped on purpose: relative targets wrap within 64K
   assign full_sum = {1'b0, i_a} + {1'b0, i_b};
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_sum <= 16'h0000;
      end else if (i_load) begin
         o_sum <= full_sum[15:0];
      end
   end
endmodule

// ---- hdl/amau_addr_unit.v ----
// Purpose: Operand addressing unit of an 8-bit CPU core
// Assumes: Decode supplies opcode mode on i_start; memory answers reads in order
// Notes: Short direct and short indirect (not indexed) forms stay in page zero; short index sums are unsigned, no wrap
//
// Overview of operation
// - Seventeen addressing modes in seven families are decoded.
// - Short direct and short indirect (not indexed) forms place the effective address in page zero.
// - Long forms reach the whole 64 Kbyte space.
// - Read-modify-write operations are refused with long forms.
// - Inherent mode fetches no operand bytes.
// - Immediate mode takes the next byte as the operand value.
// - Short direct fetches one address byte, page zero only.
// - Long direct fetches a 16-bit address from two bytes.
// - Indexed address is unsigned sum of X or Y and offset.
// - Indexed no-offset uses the index register alone.
// - Short indexed sum reaches 1FE without wrapping.
// - Long indexed adds a 16-bit offset to the index.
// - Indirect modes read a pointer and use it as address.
// - Short indirect reads a one-byte pointer, page zero.
// - Long indirect reads a two-byte pointer, full space.
// - Indirect indexed adds X or Y to the fetched pointer.
// - Short indirect indexed reaches up to 1FE.
// - Mask raise sets level 3, mask lower sets level 0.
// - Relative modes add a signed 8-bit offset to the counter.
`timescale 1ns/1ps
`include "amau_defs.vh"
module amau_addr_unit (
   // Clock and reset
   input wire I_CLK,
   input wire I_ARST_N,
   // Decode side
   input wire I_START,
   input wire [4:0] I_MODE,
   input wire I_USE_Y,
   input wire I_RMW,
   input wire I_MASK_RAISE,
   input wire I_MASK_LOWER,
   input wire [7:0] I_X,
   input wire [7:0] I_Y,
   input wire [15:0] I_PROGRAM_COUNTER,
   output wire O_BUSY,
   // Operand byte stream after the opcode
   output wire O_OPB_REQ,
   input wire I_OPB_VALID,
   input wire [7:0] I_OPB_DATA,
   // Pointer read port
   output reg O_PTR_REQ,
   output reg [15:0] O_PTR_ADDR,
   input wire I_PTR_VALID,
   input wire [7:0] I_PTR_DATA,
   // Results
   output reg O_EA_VALID,
   output reg [15:0] O_EA,
   output reg O_IMM_VALID,
   output reg [7:0] O_IMM,
   output reg O_BRANCH_VALID,
   output reg [15:0] O_BRANCH_TARGET,
   output reg O_MODE_ERR,
   output reg [2:0] O_FAMILY,
   output reg [1:0] O_INT_MASK
);

   ////////////////////////////////////////////////////////////////
   localparam ST_IDLE = 3'h0;
   localparam ST_OPB = 3'h1;
   localparam ST_PTR = 3'h2;
   localparam ST_SUM = 3'h3;
   localparam ST_DONE = 3'h4;

   reg [2:0] state;
   reg [2:0] next_state;
   reg [4:0] mode;
   reg use_y;
   reg [1:0] opb_need;
   reg [1:0] opb_cnt;
   reg [1:0] ptr_need;
   reg [1:0] ptr_cnt;
   reg [15:0] opnd;
   reg [15:0] ptr;
   reg [1:0] need_opb;
   reg [1:0] need_ptr;
   reg is_long;
   reg [2:0] fam;
   wire [15:0] index16;
   reg [15:0] add_a;
   reg [15:0] add_b;
   wire [15:0] sum;

   ////////////////////////////////////////////////////////////////
   // Byte counts and family per mode
   always @* begin
      need_opb = 2'd0;
      need_ptr = 2'd0;
      is_long = 1'b0;
      fam = `AMAU_F_INH;
      case (I_MODE)
         `AMAU_M_INH: begin
            need_opb = 2'd0;
            fam = `AMAU_F_INH;
         end
         `AMAU_M_IMM: begin
            need_opb = 2'd1;
            fam = `AMAU_F_IMM;
         end
         `AMAU_M_DIR_S: begin
            need_opb = 2'd1;
            fam = `AMAU_F_DIR;
         end
         `AMAU_M_DIR_L: begin
            need_opb = 2'd2;
            is_long = 1'b1;
            fam = `AMAU_F_DIR;
         end
         `AMAU_M_IDX_0: begin
            need_opb = 2'd0;
            fam = `AMAU_F_IDX;
         end
         `AMAU_M_IDX_S: begin
            need_opb = 2'd1;
            fam = `AMAU_F_IDX;
         end
         `AMAU_M_IDX_L: begin
            need_opb = 2'd2;
            is_long = 1'b1;
            fam = `AMAU_F_IDX;
         end
         `AMAU_M_IND_S, `AMAU_M_INX_S: begin
            need_opb = 2'd1;
            need_ptr = 2'd1;
            fam = `AMAU_F_IND;
         end
         `AMAU_M_IND_L, `AMAU_M_INX_L: begin
            need_opb = 2'd1;
            need_ptr = 2'd2;
            is_long = 1'b1;
            fam = `AMAU_F_IND;
         end
         `AMAU_M_REL_D: begin
            need_opb = 2'd1;
            fam = `AMAU_F_REL;
         end
         `AMAU_M_REL_I: begin
            need_opb = 2'd1;
            need_ptr = 2'd1;
            fam = `AMAU_F_REL;
         end
         `AMAU_M_BIT_D: begin
            need_opb = 2'd1;
            fam = `AMAU_F_BIT;
         end
         `AMAU_M_BIT_I: begin
            need_opb = 2'd1;
            need_ptr = 2'd1;
            fam = `AMAU_F_BIT;
         end
         `AMAU_M_BTR_D: begin
            need_opb = 2'd2;
            fam = `AMAU_F_BIT;
         end
         `AMAU_M_BTR_I: begin
            need_opb = 2'd2;
            need_ptr = 2'd1;
            fam = `AMAU_F_BIT;
         end
         default: begin
            need_opb = 2'd0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////
   // Mode range check and refusal of long read-modify-write
   wire mode_ok = (I_MODE <= `AMAU_M_BTR_I);
   wire refuse = !mode_ok || (I_RMW && is_long);
   wire accept = (state == ST_IDLE) && I_START && !refuse;

   assign O_BUSY = (state != ST_IDLE);
   assign O_OPB_REQ = (state == ST_OPB);
   assign index16 = {`AMAU_PAGE0_HI, use_y ? I_Y : I_X};

   ////////////////////////////////////////////////////////////////
   // Operand adder: index plus offset or pointer, counter plus offset
   always @* begin
      add_a = index16;
      add_b = opnd;
      case (mode)
         `AMAU_M_IDX_S, `AMAU_M_IDX_L: begin
            add_a = index16;
            add_b = opnd;
         end
         `AMAU_M_INX_S, `AMAU_M_INX_L: begin
            add_a = index16;
            add_b = ptr;
         end
         `AMAU_M_REL_D: begin
            add_a = I_PROGRAM_COUNTER;
            add_b = {{8{opnd[7]}}, opnd[7:0]};
         end
         `AMAU_M_REL_I: begin
            add_a = I_PROGRAM_COUNTER;
            add_b = {{8{ptr[7]}}, ptr[7:0]};
         end
         default: begin
            add_a = index16;
            add_b = opnd;
         end
      endcase
   end

   // Registered sum keeps the adder off the strobe path
   amau_add16 u_add (
      .i_clk(I_CLK),
      .i_arst_n(I_ARST_N),
      .i_load(state == ST_SUM),
      .i_a(add_a),
      .i_b(add_b),
      .o_sum(sum)
   );

   ////////////////////////////////////////////////////////////////
   // Sequencer
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (accept) begin
               if (need_opb != 2'd0) begin
                  next_state = ST_OPB;
               end else begin
                  next_state = ST_SUM;
               end
            end
         end
         ST_OPB: begin
            if (I_OPB_VALID && (opb_cnt + 2'd1 == opb_need)) begin
               next_state = (ptr_need != 2'd0) ? ST_PTR : ST_SUM;
            end
         end
         ST_PTR: begin
            if (I_PTR_VALID && (ptr_cnt + 2'd1 == ptr_need)) begin
               next_state = ST_SUM;
            end
         end
         ST_SUM: begin
            next_state = ST_DONE;
         end
         ST_DONE: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         state <= ST_IDLE;
         mode <= `AMAU_M_INH;
         use_y <= 1'b0;
         opb_need <= 2'd0;
         opb_cnt <= 2'd0;
         ptr_need <= 2'd0;
         ptr_cnt <= 2'd0;
         opnd <= 16'h0000;
         ptr <= 16'h0000;
         O_PTR_REQ <= 1'b0;
         O_PTR_ADDR <= 16'h0000;
         O_MODE_ERR <= 1'b0;
         O_FAMILY <= `AMAU_F_INH;
         O_INT_MASK <= `AMAU_MASK_HI;
      end else begin
         state <= next_state;
         O_MODE_ERR <= (state == ST_IDLE) && I_START && refuse;
         // Mask changes are inherent and take effect at the next clock edge in any state
         if (I_MASK_RAISE) begin
            O_INT_MASK <= `AMAU_MASK_HI;
         end else if (I_MASK_LOWER) begin
            O_INT_MASK <= `AMAU_MASK_LO;
         end
         if (accept) begin
            mode <= I_MODE;
            use_y <= I_USE_Y;
            opb_need <= need_opb;
            ptr_need <= need_ptr;
            opb_cnt <= 2'd0;
            ptr_cnt <= 2'd0;
            opnd <= 16'h0000;
            ptr <= 16'h0000;
            O_FAMILY <= fam;
         end
         if ((state == ST_OPB) && I_OPB_VALID) begin
            // High byte first for two-byte fields
            opnd <= {opnd[7:0], I_OPB_DATA};
            opb_cnt <= opb_cnt + 2'd1;
            if ((opb_cnt + 2'd1 == opb_need) && (ptr_need != 2'd0)) begin
               O_PTR_REQ <= 1'b1;
               // Pointer lives in page zero; bit-relative pointer is first byte
               if (opb_need == 2'd2) begin
                  O_PTR_ADDR <= {`AMAU_PAGE0_HI, opnd[7:0]};
               end else begin
                  O_PTR_ADDR <= {`AMAU_PAGE0_HI, I_OPB_DATA};
               end
            end
         end
         if ((state == ST_PTR) && I_PTR_VALID) begin
            ptr <= {ptr[7:0], I_PTR_DATA};
            ptr_cnt <= ptr_cnt + 2'd1;
            O_PTR_ADDR <= O_PTR_ADDR + `AMAU_ONE16;
            if (ptr_cnt + 2'd1 == ptr_need) begin
               O_PTR_REQ <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // Result stage
   always @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         O_EA_VALID <= 1'b0;
         O_EA <= 16'h0000;
         O_IMM_VALID <= 1'b0;
         O_IMM <= `AMAU_ZERO8;
         O_BRANCH_VALID <= 1'b0;
         O_BRANCH_TARGET <= 16'h0000;
      end else begin
         O_EA_VALID <= 1'b0;
         O_IMM_VALID <= 1'b0;
         O_BRANCH_VALID <= 1'b0;
         if (state == ST_DONE) begin
            case (mode)
               `AMAU_M_IMM: begin
                  O_IMM <= opnd[7:0];
                  O_IMM_VALID <= 1'b1;
               end
               `AMAU_M_DIR_S, `AMAU_M_BIT_D, `AMAU_M_BTR_D: begin
                  // Bit-relative: address byte came first
                  O_EA <= {`AMAU_PAGE0_HI,
                     (mode == `AMAU_M_BTR_D) ? opnd[15:8] : opnd[7:0]};
                  O_EA_VALID <= 1'b1;
               end
               `AMAU_M_DIR_L: begin
                  O_EA <= opnd;
                  O_EA_VALID <= 1'b1;
               end
               `AMAU_M_IDX_0: begin
                  O_EA <= index16;
                  O_EA_VALID <= 1'b1;
               end
               `AMAU_M_IDX_S, `AMAU_M_IDX_L, `AMAU_M_INX_S, `AMAU_M_INX_L: begin
                  // Full carry kept so short sums reach 1FE
                  O_EA <= sum;
                  O_EA_VALID <= 1'b1;
               end
               `AMAU_M_IND_S, `AMAU_M_BIT_I, `AMAU_M_BTR_I: begin
                  O_EA <= {`AMAU_PAGE0_HI, ptr[7:0]};
                  O_EA_VALID <= 1'b1;
               end
               `AMAU_M_IND_L: begin
                  O_EA <= ptr;
                  O_EA_VALID <= 1'b1;
               end
               `AMAU_M_REL_D, `AMAU_M_REL_I: begin
                  O_BRANCH_TARGET <= sum;
                  O_BRANCH_VALID <= 1'b1;
               end
               default: begin
                  O_EA_VALID <= 1'b0;
               end
            endcase
         end
      end
   end

endmodule

// ---- verif/amau_addr_checker.sv ----
// Purpose: Port-level properties of the operand address unit
// Assumes: Bound to amau_addr_unit, one clock domain
// Notes: Mode of the last taken start is kept in helper logic
`timescale 1ns/1ps
`include "amau_defs.vh"
module amau_addr_checker (
   // Clock and reset
   input wire I_CLK,
   input wire I_ARST_N,
   // Decode side
   input wire I_START,
   input wire [4:0] I_MODE,
   input wire I_RMW,
   input wire I_MASK_RAISE,
   input wire I_MASK_LOWER,
   input wire O_BUSY,
   // Byte ports
   input wire O_OPB_REQ,
   input wire I_OPB_VALID,
   input wire [7:0] I_OPB_DATA,
   input wire O_PTR_REQ,
   input wire [15:0] O_PTR_ADDR,
   // Results
   input wire O_EA_VALID,
   input wire [15:0] O_EA,
   input wire O_IMM_VALID,
   input wire [7:0] O_IMM,
   input wire O_MODE_ERR,
   input wire [1:0] O_INT_MASK
);
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_ARST_N);
   reg [4:0] md;
   wire take = I_START && !O_BUSY;
   wire long_m = I_MODE == `AMAU_M_DIR_L || I_MODE == `AMAU_M_IDX_L ||
      I_MODE == `AMAU_M_IND_L || I_MODE == `AMAU_M_INX_L;
   wire pg0 = md == `AMAU_M_DIR_S || md == `AMAU_M_IND_S || md == `AMAU_M_IDX_0;
   wire sidx = md == `AMAU_M_IDX_S || md == `AMAU_M_INX_S;
   always @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         md <= 5'h00;
      end else if (take) begin
         md <= I_MODE;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   sequence imm_take;
      md == `AMAU_M_IMM && O_OPB_REQ && I_OPB_VALID;
   endsequence
   sequence imm_out;
      ##3 O_IMM_VALID && O_IMM == $past(I_OPB_DATA, 3);
   endsequence
   mask_raise_a: assert property (I_MASK_RAISE |=> O_INT_MASK == 2'h3)
      else $error("mask not raised to 3");
   mask_lower_a: assert property (I_MASK_LOWER && !I_MASK_RAISE |=> O_INT_MASK == 2'h0)
      else $error("mask not lowered to 0");
   mask_hold_a: assert property (!I_MASK_LOWER && !I_MASK_RAISE |=> $stable(O_INT_MASK))
      else $error("mask changed without request");
   long_rmw_a: assert property (take && I_RMW && long_m |=> O_MODE_ERR)
      else $error("rmw with long form not refused");
   bad_mode_a: assert property (take && I_MODE > 5'h10 |=> O_MODE_ERR)
      else $error("illegal mode not refused");
   inh_nofetch_a: assert property (take && I_MODE == `AMAU_M_INH |=>
      (!O_OPB_REQ && !O_PTR_REQ) [*3])
      else $error("inherent mode fetched bytes");
   page_zero_a: assert property (O_EA_VALID && pg0 |-> O_EA[15:8] == 8'h00)
      else $error("short form left page zero");
   short_idx_a: assert property (O_EA_VALID && sidx |-> O_EA <= 16'h01fe)
      else $error("short indexed beyond 1fe");
   ptr_page_a: assert property (O_PTR_REQ |-> O_PTR_ADDR[15:8] == 8'h00)
      else $error("pointer address off page zero");
   imm_data_a: assert property (imm_take |-> imm_out)
      else $error("immediate byte not passed on");
endmodule

// ---- verif/amau_mem_model.sv ----
// Purpose: Fetch path and memory bus model facing the address unit
// Assumes: Bench loads the byte stream before each start
// Notes: Pointer memory holds low address byte plus 30h
`timescale 1ns/1ps
module amau_mem_model (
   input wire i_clk,
   input wire i_opb_req,
   input wire i_ptr_req,
   input wire [15:0] i_ptr_addr,
   output reg o_opb_valid,
   output reg [7:0] o_opb_data,
   output reg o_ptr_valid,
   output reg [7:0] o_ptr_data
);
   reg [7:0] stream [0:2];
   integer idx;
   reg slow;
   initial begin
      o_opb_valid = 1'b0;
      o_opb_data = 8'h00;
      o_ptr_valid = 1'b0;
      o_ptr_data = 8'h00;
      idx = 0;
      slow = 1'b0;
   end
   // Valid is only offered while wanted, so valid at an edge means taken
   always @(posedge i_clk) begin
      if (o_opb_valid) begin
         idx = idx + 1;
      end
      #1;
      o_opb_valid = i_opb_req && !(slow && o_opb_valid);
      // Idle lines toggle so a stale byte is never mistaken for data
      o_opb_data = o_opb_valid ? stream[idx % 3] : ~o_opb_data;
      o_ptr_valid = i_ptr_req && !(slow && o_ptr_valid);
      o_ptr_data = o_ptr_valid ? i_ptr_addr[7:0] + 8'h30 : ~o_ptr_data;
   end
endmodule

// ---- verif/addressing_mode_address_unit_bench.sv ----
// Purpose: Self-checking bench for the operand address unit
// Assumes: X=ffh, Y=80h, counter 1000h throughout
// Notes: Two-byte fields are sent high byte first
`timescale 1ns/1ps
`include "amau_defs.vh"
module addressing_mode_address_unit_bench;
   reg I_CLK = 1'b0;
   reg I_ARST_N = 1'b0;
   reg I_START = 1'b0;
   reg [4:0] I_MODE = 5'h00;
   reg I_USE_Y = 1'b0;
   reg I_RMW = 1'b0;
   reg I_MASK_RAISE = 1'b0;
   reg I_MASK_LOWER = 1'b0;
   reg [7:0] I_X = 8'hff;
   reg [7:0] I_Y = 8'h80;
   reg [15:0] I_PROGRAM_COUNTER = 16'h1000;
   wire O_BUSY, O_OPB_REQ, I_OPB_VALID, O_PTR_REQ, I_PTR_VALID;
   wire O_EA_VALID, O_IMM_VALID, O_BRANCH_VALID, O_MODE_ERR;
   wire [7:0] I_OPB_DATA, I_PTR_DATA, O_IMM;
   wire [15:0] O_PTR_ADDR, O_EA, O_BRANCH_TARGET;
   wire [2:0] O_FAMILY;
   wire [1:0] O_INT_MASK;
   integer n_fail = 0;
   integer checked = 0;
   always #5 I_CLK = ~I_CLK;
   amau_addr_unit DUT (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .I_START(I_START),
      .I_MODE(I_MODE), .I_USE_Y(I_USE_Y), .I_RMW(I_RMW), .I_MASK_RAISE(I_MASK_RAISE),
      .I_MASK_LOWER(I_MASK_LOWER), .I_X(I_X), .I_Y(I_Y),
      .I_PROGRAM_COUNTER(I_PROGRAM_COUNTER), .O_BUSY(O_BUSY), .O_OPB_REQ(O_OPB_REQ),
      .I_OPB_VALID(I_OPB_VALID), .I_OPB_DATA(I_OPB_DATA), .O_PTR_REQ(O_PTR_REQ),
      .O_PTR_ADDR(O_PTR_ADDR), .I_PTR_VALID(I_PTR_VALID), .I_PTR_DATA(I_PTR_DATA),
      .O_EA_VALID(O_EA_VALID), .O_EA(O_EA), .O_IMM_VALID(O_IMM_VALID), .O_IMM(O_IMM),
      .O_BRANCH_VALID(O_BRANCH_VALID), .O_BRANCH_TARGET(O_BRANCH_TARGET),
      .O_MODE_ERR(O_MODE_ERR), .O_FAMILY(O_FAMILY), .O_INT_MASK(O_INT_MASK));
   amau_mem_model P (.i_clk(I_CLK), .i_opb_req(O_OPB_REQ), .i_ptr_req(O_PTR_REQ),
      .i_ptr_addr(O_PTR_ADDR), .o_opb_valid(I_OPB_VALID), .o_opb_data(I_OPB_DATA),
      .o_ptr_valid(I_PTR_VALID), .o_ptr_data(I_PTR_DATA));
   ////////////////////////////////////////////////////////////////////////////////
   task cmp(input ok, input [15:0] got, input [15:0] exp);
      begin
         checked = checked + 1;
         if (ok !== 1'b1 || got !== exp) begin
            n_fail = n_fail + 1;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
         end
      end
   endtask
   task end_of_test;
      begin
         $display("checked %0d n_fail %0d", checked, n_fail);
         if (n_fail == 0 && checked > 0) $display("No errors found");
         else $display("Errors were found");
         $finish;
      end
   endtask
   // Kind: 0 address, 1 immediate, 2 branch, 3 refusal, 4 no result
   task op(input [4:0] m, input y, input r, input [7:0] b0, input [7:0] b1,
      input [2:0] k, input [15:0] e, input [2:0] f);
      integer n;
      begin
         P.stream[0] = b0;
         P.stream[1] = b1;
         P.idx = 0;
         I_MODE = m;
         I_USE_Y = y;
         I_RMW = r;
         I_START = 1'b1;
         @(posedge I_CLK);
         #1 I_START = 1'b0;
         n = 0;
         if (k == 4) begin
            repeat (3) @(posedge I_CLK);
            #1 n = 0;
         end else while (n < 40 && (O_EA_VALID | O_IMM_VALID | O_BRANCH_VALID | O_MODE_ERR)
            !== 1'b1) begin
            @(posedge I_CLK);
            #1 n = n + 1;
         end
         case (k)
            0: cmp(O_EA_VALID, O_EA, e);
            1: cmp(O_IMM_VALID, {8'h00, O_IMM}, e);
            2: cmp(O_BRANCH_VALID, O_BRANCH_TARGET, e);
            3: cmp(O_MODE_ERR, 16'h0000, e);
            default: cmp(!O_BUSY, P.idx[15:0], e);
         endcase
         if (k != 3) begin
            cmp(1'b1, {13'h0000, O_FAMILY}, {13'h0000, f});
         end else begin
            // Refused start leaves the unit idle once the pulse ends
            @(posedge I_CLK);
            #1 cmp(!O_BUSY && !O_MODE_ERR, 16'h0000, 16'h0000);
         end
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task t_plain;
      begin
         op(`AMAU_M_INH, 0, 0, 8'h11, 8'h22, 4, 16'h0000, 3'h0);
         op(`AMAU_M_IMM, 0, 0, 8'h55, 8'h22, 1, 16'h0055, 3'h1);
         op(`AMAU_M_DIR_S, 0, 0, 8'hff, 8'h22, 0, 16'h00ff, 3'h2);
         op(`AMAU_M_DIR_L, 0, 0, 8'h12, 8'h34, 0, 16'h1234, 3'h2);
         $display("test plain done");
      end
   endtask
   task t_index;
      begin
         op(`AMAU_M_IDX_0, 0, 0, 8'h11, 8'h22, 0, 16'h00ff, 3'h3);
         op(`AMAU_M_IDX_0, 1, 0, 8'h11, 8'h22, 0, 16'h0080, 3'h3);
         op(`AMAU_M_IDX_S, 0, 0, 8'hff, 8'h22, 0, 16'h01fe, 3'h3);
         op(`AMAU_M_IDX_L, 1, 0, 8'h12, 8'h34, 0, 16'h12b4, 3'h3);
         $display("test index done");
      end
   endtask
   task t_indirect;
      begin
         P.slow = 1'b1;
         op(`AMAU_M_IND_S, 0, 0, 8'h10, 8'h22, 0, 16'h0040, 3'h4);
         op(`AMAU_M_IND_L, 0, 0, 8'h10, 8'h22, 0, 16'h4041, 3'h4);
         op(`AMAU_M_INX_S, 0, 0, 8'h20, 8'h22, 0, 16'h014f, 3'h4);
         op(`AMAU_M_INX_L, 1, 0, 8'h20, 8'h22, 0, 16'h50d1, 3'h4);
         P.slow = 1'b0;
         $display("test indirect done");
      end
   endtask
   task t_rel_bit;
      begin
         op(`AMAU_M_REL_D, 0, 0, 8'h80, 8'h22, 2, 16'h0f80, 3'h5);
         op(`AMAU_M_REL_I, 0, 0, 8'h10, 8'h22, 2, 16'h1040, 3'h5);
         op(`AMAU_M_BIT_D, 0, 1, 8'h10, 8'h22, 0, 16'h0010, 3'h6);
         op(`AMAU_M_BIT_I, 0, 1, 8'h10, 8'h22, 0, 16'h0040, 3'h6);
         op(`AMAU_M_BTR_D, 0, 0, 8'h10, 8'h05, 0, 16'h0010, 3'h6);
         op(`AMAU_M_BTR_I, 0, 0, 8'h10, 8'h05, 0, 16'h0040, 3'h6);
         $display("test relative and bit done");
      end
   endtask
   task t_refuse;
      begin
         op(`AMAU_M_DIR_L, 0, 1, 8'h12, 8'h34, 3, 16'h0000, 3'h0);
         op(`AMAU_M_INX_L, 0, 1, 8'h12, 8'h34, 3, 16'h0000, 3'h0);
         op(5'h11, 0, 0, 8'h12, 8'h34, 3, 16'h0000, 3'h0);
         op(`AMAU_M_DIR_S, 0, 1, 8'h12, 8'h34, 0, 16'h0012, 3'h2);
         $display("test refusal done");
      end
   endtask
   task t_mask;
      begin
         cmp(1'b1, {14'h0000, O_INT_MASK}, 16'h0003);
         I_MASK_LOWER = 1'b1;
         @(posedge I_CLK);
         #1 I_MASK_LOWER = 1'b0;
         cmp(1'b1, {14'h0000, O_INT_MASK}, 16'h0000);
         {I_MASK_RAISE, I_MASK_LOWER} = 2'h3;
         @(posedge I_CLK);
         #1 {I_MASK_RAISE, I_MASK_LOWER} = 2'h0;
         cmp(1'b1, {14'h0000, O_INT_MASK}, 16'h0003);
         $display("test mask done");
      end
   endtask
   initial begin
      repeat (16) @(posedge I_CLK);
      #1 I_ARST_N = 1'b1;
      t_mask;
      t_plain;
      t_index;
      t_indirect;
      t_rel_bit;
      t_refuse;
      end_of_test;
   end
   // Whole run needs well under 2000 cycles
   initial begin
      #100000;
      n_fail = n_fail + 1;
      end_of_test;
   end
endmodule
bind amau_addr_unit amau_addr_checker CHK (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N),
   .I_START(I_START), .I_MODE(I_MODE), .I_RMW(I_RMW), .I_MASK_RAISE(I_MASK_RAISE),
   .I_MASK_LOWER(I_MASK_LOWER), .O_BUSY(O_BUSY), .O_OPB_REQ(O_OPB_REQ),
   .I_OPB_VALID(I_OPB_VALID), .I_OPB_DATA(I_OPB_DATA), .O_PTR_REQ(O_PTR_REQ),
   .O_PTR_ADDR(O_PTR_ADDR), .O_EA_VALID(O_EA_VALID), .O_EA(O_EA),
   .O_IMM_VALID(O_IMM_VALID), .O_IMM(O_IMM), .O_MODE_ERR(O_MODE_ERR),
   .O_INT_MASK(O_INT_MASK));
